/* rtl/upcrs_pkg.sv */
// constants, register map and types of the usb phy clock/reset sequencer
package upcrs_pkg;

  // =====================================================================
  // clocking and timing
  localparam int unsigned CLK_FREQ_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int unsigned OSC32K_HZ = 32_000;
  localparam int unsigned OSC32K_DIV_CYC = CLK_FREQ_HZ / OSC32K_HZ;
  localparam int unsigned OSC32K_PERIOD_NS = 1_000_000_000 / OSC32K_HZ;
  // low-power oscillator start-up allowance, least time
  localparam int unsigned OSC_START_NS = 125_000;
  localparam int unsigned OSC_START_CYC =
    (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power control reset delay, least time, counted in slow ticks
  localparam int unsigned PWR_RST_NS = 61_000;
  localparam int unsigned PWR_RST_TICKS =
    (PWR_RST_NS + OSC32K_PERIOD_NS - 1) / OSC32K_PERIOD_NS;
  // hard reset release to direction falling, longest time
  localparam int unsigned DIR_MAX_NS = 647_000;
  localparam int unsigned DIR_MAX_CYC = DIR_MAX_NS / CLK_PERIOD_NS;
  // rising edges on the reference pin that prove a running clock
  localparam int unsigned REF_EDGES = 4;

  // =====================================================================
  // register map and fields
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [2:0] LDO_VSEL_RST = 3'h3;
  localparam int unsigned CTRL_VSEL_LSB = 0;
  localparam int unsigned ST_CLK_OUT = 0;
  localparam int unsigned ST_REF_26M = 1;
  localparam int unsigned ST_OSC_OK = 2;
  localparam int unsigned ST_PLL_LOCK = 3;
  localparam int unsigned ST_DIR = 4;
  localparam int unsigned ST_PHY_RST = 5;
  localparam int unsigned ST_LATE = 6;
  localparam int unsigned ST_EDGES_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer phases, starting with the wait for the slow oscillator
  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_PWR_RST,
    SEQ_PLL_WAIT,
    SEQ_READY
  } upcrs_seq_t;

endpackage

/* rtl/upcrs_sync.sv */
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ns
module upcrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* rtl/upcrs_top.sv */
// usb phy clock mode selection, reset fan-out and power-up sequencing
//
// Notes on behaviour
// - clock pin stays an input after any reset until a reference is seen.
// - a running reference turns the clock pin into a 60 MHz output.
// - four rising reference edges are the proof of a running reference.
// - config pin low means 19.2 MHz reference, high means 26 MHz.
// - chip select low or battery absent holds all but the synchroniser and the axi4-lite port in reset.
// - chip select low powers down and tri-states the whole bus.
// - io supply absent resets all but the slow oscillator domain; the 3.3 V regulator enable also stays on.
// - phy logic resets on any missing supply or hard reset pin low.
// - hard reset returns registers to defaults and tri-states the bus.
// - an internal 32 kHz clock paces the power-up timers.
// - pll lock and direction fall within 0.647 ms of hard reset release.
// - wait about 61 us after power control reset before next steps.
// - allow 125 us for the slow oscillator before trusting it.
// - 3-bit regulator select, eight levels, default code 011.
// - the 3.3 V regulator is on whenever the device is enabled.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module upcrs_top
  import upcrs_pkg::*;
#(
  parameter int AW = 8,
  parameter int DIR_MAX = DIR_MAX_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device pins and supply monitors, all asynchronous
  input wire logic chip_select,
  input wire logic battery_present,
  input wire logic io_supply,
  input wire logic core_supply_ok,
  input wire logic ext_supply_ok,
  input wire logic usb_supply_ok,
  input wire logic hard_reset_n,
  input wire logic reference_clock_in,
  input wire logic ref_freq_select,
  input wire logic pll_locked,
  // sequencer outputs
  output logic dir_out,
  output logic dir_oe,
  output logic bus_oe,
  output logic clock_pin_oe,
  output logic pll_enable,
  output logic pll_ref_external,
  output logic ref_is_26mhz,
  output logic ldo33_enable,
  output logic [2:0] ldo_voltage_select
);

  // =====================================================================
  // pin synchronisation
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pins_s;
  logic cs_s, bat_s, io_s, v15_s, v18_s, v33_s;
  logic hrst_n_s, ref_s, cfg_s, lock_s;

  upcrs_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({chip_select, battery_present, io_supply, core_supply_ok,
        ext_supply_ok, usb_supply_ok, hard_reset_n, reference_clock_in,
        ref_freq_select, pll_locked}),
    .q(pins_s)
  );

  assign {cs_s, bat_s, io_s, v15_s, v18_s, v33_s,
          hrst_n_s, ref_s, cfg_s, lock_s} = pins_s;

  // =====================================================================
  // reset fan-out
  logic all_rst_r, phy_rst_r;
  logic core_rst;

  assign core_rst = !cs_s || !bat_s || !io_s;

  // registered so a glitch on a monitor cannot half-reset a domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      all_rst_r <= 1'b1;
      phy_rst_r <= 1'b1;
    end else begin
      all_rst_r <= !cs_s || !bat_s;
      phy_rst_r <= core_rst || !v15_s || !v18_s || !v33_s || !hrst_n_s;
    end
  end

  // =====================================================================
  // slow 32 kHz oscillator domain
  localparam int DIVW = $clog2(OSC32K_DIV_CYC);
  localparam int STW = $clog2(OSC_START_CYC + 1);
  logic [DIVW-1:0] osc_div_r;
  logic [STW-1:0] osc_start_r;
  logic osc_ok_r;
  logic osc_tick_r;

  // slow tick derived from the core clock, survives io loss
  always_ff @(posedge aclk) begin
    if (!aresetn || all_rst_r) begin
      osc_div_r <= '0;
      osc_tick_r <= 1'b0;
    end else if (osc_div_r == DIVW'(OSC32K_DIV_CYC - 1)) begin
      osc_div_r <= '0;
      osc_tick_r <= osc_ok_r;
    end else begin
      osc_div_r <= osc_div_r + 1'b1;
      osc_tick_r <= 1'b0;
    end
  end

  // ticks are ignored until start-up time has passed
  always_ff @(posedge aclk) begin
    if (!aresetn || all_rst_r) begin
      osc_start_r <= '0;
      osc_ok_r <= 1'b0;
    end else if (osc_start_r == STW'(OSC_START_CYC - 1)) begin
      osc_ok_r <= 1'b1;
    end else begin
      osc_start_r <= osc_start_r + 1'b1;
    end
  end

  // =====================================================================
  // reference clock detection and clock mode
  logic ref_prev_r;
  logic [2:0] ref_edges_r;
  logic clk_out_mode_r;

  // a 19.2 or 26 MHz reference sampled at 25 MHz aliases; edges seen
  // are only a presence test, never a frequency measurement
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      ref_prev_r <= 1'b0;
      ref_edges_r <= '0;
    end else begin
      ref_prev_r <= ref_s;
      if (ref_s && !ref_prev_r && ref_edges_r != 3'(REF_EDGES)) begin
        ref_edges_r <= ref_edges_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      clk_out_mode_r <= 1'b0;
    end else if (ref_edges_r == 3'(REF_EDGES)) begin
      clk_out_mode_r <= 1'b1;
    end
  end

  // =====================================================================
  // power-up sequencer
  upcrs_seq_t state_r;
  logic [3:0] tick_cnt_r;

  // one extra tick because the first tick lands at a random phase
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      state_r <= SEQ_OFF;
      tick_cnt_r <= '0;
    end else begin
      case (state_r)
        SEQ_OFF: begin
          if (osc_ok_r) begin
            state_r <= SEQ_PWR_RST;
          end
        end
        SEQ_PWR_RST: begin
          if (osc_tick_r) begin
            if (tick_cnt_r == 4'(PWR_RST_TICKS)) begin
              state_r <= SEQ_PLL_WAIT;
            end else begin
              tick_cnt_r <= tick_cnt_r + 1'b1;
            end
          end
        end
        SEQ_PLL_WAIT: begin
          if (lock_s) begin
            state_r <= SEQ_READY;
          end
        end
        SEQ_READY: begin
          if (!lock_s) begin
            state_r <= SEQ_PLL_WAIT;
          end
        end
        default: begin
          state_r <= SEQ_OFF;
        end
      endcase
    end
  end

  // =====================================================================
  // direction deadline watch
  localparam int DLW = $clog2(DIR_MAX + 1);
  logic [DLW-1:0] dl_cnt_r;
  logic dl_hit;

  // count from release of phy reset until direction falls
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      dl_cnt_r <= '0;
    end else if (state_r != SEQ_READY && dl_cnt_r != DLW'(DIR_MAX)) begin
      dl_cnt_r <= dl_cnt_r + 1'b1;
    end
  end

  assign dl_hit = dl_cnt_r == DLW'(DIR_MAX - 1) && state_r != SEQ_READY;

  // =====================================================================
  // pin drivers
  // bus released while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_oe <= 1'b0;
      bus_oe <= 1'b0;
      clock_pin_oe <= 1'b0;
    end else begin
      dir_oe <= !phy_rst_r;
      bus_oe <= !phy_rst_r;
      clock_pin_oe <= !phy_rst_r && clk_out_mode_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      dir_out <= 1'b1;
      pll_enable <= 1'b0;
    end else begin
      dir_out <= state_r != SEQ_READY;
      pll_enable <= state_r == SEQ_PLL_WAIT || state_r == SEQ_READY;
    end
  end

  // clock source and reference frequency for the pll
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      pll_ref_external <= 1'b0;
      ref_is_26mhz <= 1'b0;
    end else begin
      // reference low keeps pll on the clock pin
      pll_ref_external <= clk_out_mode_r;
      // config pin picks 19.2 or 26 MHz
      ref_is_26mhz <= cfg_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ldo33_enable <= 1'b0;
    end else begin
      ldo33_enable <= !all_rst_r;
    end
  end

  // =====================================================================
  // axi4-lite slave
  logic aw_got_r, w_got_r;
  logic [AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [2:0] vsel_r;
  logic late_r;
  logic wr_fire, ar_fire;
  logic [31:0] status;

  // 0 control, 1 status, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [AW-1:0] a);
    if (a[AW-1:2] == ADDR_CTRL[AW-1:2]) begin
      return 2'd0;
    end else if (a[AW-1:2] == ADDR_STATUS[AW-1:2]) begin
      return 2'd1;
    end
    return 2'd3;
  endfunction

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // address and data are held until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_sel(aw_addr_r) == 2'd3 ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // regulator select resets to code 011
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      vsel_r <= LDO_VSEL_RST;
    end else if (wr_fire && reg_sel(aw_addr_r) == 2'd0 && w_strb_r[0]) begin
      vsel_r <= w_data_r[CTRL_VSEL_LSB +: 3];
    end
  end

  assign ldo_voltage_select = vsel_r;

  // late flag: write one to clear, a new miss in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn || phy_rst_r) begin
      late_r <= 1'b0;
    end else if (dl_hit) begin
      late_r <= 1'b1;
    end else if (wr_fire && reg_sel(aw_addr_r) == 2'd1 && w_strb_r[0] &&
                 w_data_r[ST_LATE]) begin
      late_r <= 1'b0;
    end
  end

  // status word built from live block state
  always_comb begin
    status = '0;
    status[ST_CLK_OUT] = clk_out_mode_r;
    status[ST_REF_26M] = cfg_s;
    status[ST_OSC_OK] = osc_ok_r;
    status[ST_PLL_LOCK] = lock_s;
    status[ST_DIR] = dir_out;
    status[ST_PHY_RST] = phy_rst_r;
    status[ST_LATE] = late_r;
    status[ST_EDGES_LSB +: 3] = ref_edges_r;
  end

  // read data is registered on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      case (reg_sel(s_axi_araddr))
        2'd0: begin
          s_axi_rdata <= {29'h0000_0000, vsel_r};
          s_axi_rresp <= RESP_OKAY;
        end
        2'd1: begin
          s_axi_rdata <= status;
          s_axi_rresp <= RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* verification/upcrs_top_assertions.sv */
// concurrent checks on the pins of the clock and reset sequencer
`timescale 1ns/1ns
module upcrs_top_checker
  import upcrs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_select,
  input wire logic battery_present,
  input wire logic io_supply,
  input wire logic hard_reset_n,
  input wire logic reference_clock_in,
  input wire logic ref_freq_select,
  input wire logic pll_locked,
  input wire logic dir_out,
  input wire logic dir_oe,
  input wire logic bus_oe,
  input wire logic clock_pin_oe,
  input wire logic pll_enable,
  input wire logic pll_ref_external,
  input wire logic ref_is_26mhz,
  input wire logic ldo33_enable,
  input wire logic [2:0] ldo_voltage_select
);
  logic ref_d_r;
  logic [2:0] ref_seen_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ====
  // helper
  // raw edges lead the design's synchroniser, so this count is never late
  always_ff @(posedge aclk) begin
    ref_d_r <= reference_clock_in;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_oe) begin
      ref_seen_r <= 3'h0;
    end else if (reference_clock_in && !ref_d_r && ref_seen_r != 3'h4) begin
      ref_seen_r <= ref_seen_r + 3'h1;
    end
  end

  // ====
  // checks
  reset_vals_a: assert property (
    $rose(aresetn) |-> dir_out && !bus_oe && !dir_oe && !clock_pin_oe
      && !pll_enable && !ldo33_enable && ldo_voltage_select == 3'h3)
    else $error("outputs wrong after reset");
  off_quiet_a: assert property (
    (!chip_select || !battery_present) [*6] |-> !bus_oe && !dir_oe
      && !clock_pin_oe && !pll_enable && !ldo33_enable)
    else $error("active while switched off");
  io_down_a: assert property (
    !io_supply [*6] |-> !bus_oe && !pll_enable)
    else $error("phy active without io supply");
  hard_rst_a: assert property (
    !hard_reset_n [*6] |-> !bus_oe && !dir_oe && dir_out
      && ldo_voltage_select == 3'h3)
    else $error("hard reset not applied");
  ldo33_on_a: assert property (
    (chip_select && battery_present) [*6] |-> ldo33_enable)
    else $error("regulator off while enabled");
  dir_lock_a: assert property (
    !pll_locked [*6] |-> dir_out)
    else $error("direction low without lock");
  freq_sel_a: assert property (
    (bus_oe && $stable(ref_freq_select)) [*6]
      |-> ref_is_26mhz == ref_freq_select)
    else $error("frequency select mismatch");
  clk_idle_a: assert property (
    !clock_pin_oe && ref_seen_r != 3'h4 |=> !clock_pin_oe)
    else $error("clock pin output too early");
  clk_edges_a: assert property (
    $rose(clock_pin_oe) |-> pll_ref_external && ref_seen_r == 3'h4)
    else $error("clock pin output before four edges");
  clk_out_a: assert property (
    (bus_oe && ref_seen_r == 3'h4) [*8] |-> clock_pin_oe)
    else $error("clock pin not output");
endmodule

bind upcrs_top upcrs_top_checker chk (.aclk, .aresetn, .chip_select,
  .battery_present, .io_supply, .hard_reset_n, .reference_clock_in,
  .ref_freq_select, .pll_locked, .dir_out, .dir_oe, .bus_oe, .clock_pin_oe,
  .pll_enable, .pll_ref_external, .ref_is_26mhz, .ldo33_enable,
  .ldo_voltage_select);

/* verification/upcrs_link_model.sv */
// far-side model: system reference clock and pll lock source
`timescale 1ns/1ns
module upcrs_link_model
  import upcrs_pkg::*;
#(
  parameter int HALF = 4,
  parameter int LOCK_CYC = 20
) (
  input wire logic aclk,
  input wire logic ref_run,
  input wire logic pll_enable,
  output logic reference_clock_in,
  output logic pll_locked
);
  logic ref_r = 1'b0;
  logic lock_r = 1'b0;
  int div_r = 0;
  int lock_cnt_r = 0;

  assign reference_clock_in = ref_r;
  assign pll_locked = lock_r;

  // ====
  // reference pin, slowed so a 25 MHz sampler sees every edge
  // held low unless output clock mode is wanted
  always @(posedge aclk) begin
    div_r <= (ref_run && div_r < HALF - 1) ? div_r + 1 : 0;
    if (!ref_run)
      ref_r <= 1'b0;
    else if (div_r == HALF - 1)
      ref_r <= !ref_r;
  end

  // lock a fixed time after enable, lost at once when disabled
  always @(posedge aclk) begin
    if (!pll_enable)
      lock_cnt_r <= 0;
    else if (lock_cnt_r < LOCK_CYC)
      lock_cnt_r <= lock_cnt_r + 1;
    lock_r <= pll_enable && lock_cnt_r == LOCK_CYC;
  end
endmodule

/* verification/upcrs_top_tb_top.sv */
// self-checking bench for the usb phy clock and reset sequencer
`timescale 1ns/1ns
module upcrs_top_tb_top
  import upcrs_pkg::*;
;
  typedef struct {
    logic [7:0] a;
    logic [3:0] d;
    logic s;
    logic [1:0] br;
    logic [3:0] rd;
    logic [1:0] rr;
  } upcrs_row_t;

  localparam int REF_HALF = 4;
  // short deadline so the late flag is set during every power-up
  localparam int LATE_CYC = 200;
  localparam logic [31:0] YES = 32'h0000_0001;
  // every code, a write with lane 0 off, then an unmapped place
  upcrs_row_t rows [10] = '{
    '{8'h00, 4'h0, 1'b1, 2'h0, 4'h0, 2'h0},
    '{8'h00, 4'h1, 1'b1, 2'h0, 4'h1, 2'h0},
    '{8'h00, 4'h2, 1'b1, 2'h0, 4'h2, 2'h0},
    '{8'h00, 4'h3, 1'b1, 2'h0, 4'h3, 2'h0},
    '{8'h00, 4'h4, 1'b1, 2'h0, 4'h4, 2'h0},
    '{8'h00, 4'h5, 1'b1, 2'h0, 4'h5, 2'h0},
    '{8'h00, 4'h6, 1'b1, 2'h0, 4'h6, 2'h0},
    '{8'h00, 4'h7, 1'b1, 2'h0, 4'h7, 2'h0},
    '{8'h00, 4'h2, 1'b0, 2'h0, 4'h7, 2'h0},
    '{8'h08, 4'h5, 1'b1, 2'h2, 4'h0, 2'h2}};

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r2;
  logic [31:0] rdata, r32;
  logic [5:0] pw = 6'h3f;
  logic hrst_n = 1'b1, cfg = 1'b0, ref_run = 1'b0;
  logic ref_pin, locked, dir_out, dir_oe, bus_oe, clk_oe, pll_en;
  logic ref_ext, is26, ldo_en;
  logic [2:0] vsel;
  logic [5:0] pins;
  int bad_count = 0, n_tests = 0, c, i;

  assign pins = {ldo_en, pll_en, bus_oe, dir_oe, clk_oe, dir_out};

  upcrs_top #(.DIR_MAX(LATE_CYC)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chip_select(pw[4]), .battery_present(pw[5]), .io_supply(pw[3]),
    .core_supply_ok(pw[0]), .ext_supply_ok(pw[1]), .usb_supply_ok(pw[2]),
    .hard_reset_n(hrst_n), .reference_clock_in(ref_pin),
    .ref_freq_select(cfg), .pll_locked(locked), .dir_out(dir_out),
    .dir_oe(dir_oe), .bus_oe(bus_oe), .clock_pin_oe(clk_oe),
    .pll_enable(pll_en), .pll_ref_external(ref_ext), .ref_is_26mhz(is26),
    .ldo33_enable(ldo_en), .ldo_voltage_select(vsel));

  upcrs_link_model #(.HALF(REF_HALF)) LINK (.aclk(aclk), .ref_run(ref_run),
    .pll_enable(pll_en), .reference_clock_in(ref_pin), .pll_locked(locked));

  initial forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;

  // ====
  // tasks
  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask

  // ready is sampled mid-cycle, so the edge after decides the handshake
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic s, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && b !== 1'b1; n++) begin
      @(negedge aclk);
      aw = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (b !== 1'b1) fail("no write answer");
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar, v;
    v = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && v !== 1'b1; n++) begin
      @(negedge aclk);
      ar = arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (v !== 1'b1) fail("no read answer");
  endtask

  // bounded wait for a level; returns at a falling edge
  task automatic wt(ref logic s, input logic v, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (n < 20000 && s !== v);
    if (s !== v) fail("wait timed out");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ====
  // sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wt(pll_en, 1'b1, c);
    i = OSC_START_CYC + PWR_RST_TICKS * OSC32K_DIV_CYC;
    chk(32'(c >= i), YES, "pll early");
    wt(dir_out, 1'b0, i);
    chk(32'(c + i <= DIR_MAX_CYC), YES, "dir late");
    chk(32'({pins, ref_ext}), 32'h0000_0078, "input mode");
    @(posedge aclk);
    axr(ADDR_STATUS[7:0], r32, r2);
    chk(r32, 32'h0000_004C, "status up");
    // late flag is write-one-to-clear and stays clear once saturated
    axw(ADDR_STATUS[7:0], 32'h0000_0040, 1'b1, r2);
    chk(32'(r2), 32'(RESP_OKAY), "clear resp");
    axr(ADDR_STATUS[7:0], r32, r2);
    chk(r32, 32'h0000_000C, "late cleared");
    foreach (rows[k]) begin
      axw(rows[k].a, 32'(rows[k].d), rows[k].s, r2);
      chk(32'(r2), 32'(rows[k].br), "write resp");
      axr(rows[k].a, r32, r2);
      chk(r32, 32'(rows[k].rd), "read data");
      chk(32'(r2), 32'(rows[k].rr), "read resp");
      if (rows[k].a == 8'h00)
        chk(32'(vsel), 32'(rows[k].rd), "vsel pin");
    end
    // reference appears: clock pin turns output
    cfg <= 1'b1;
    ref_run <= 1'b1;
    wt(clk_oe, 1'b1, c);
    chk(32'(c >= 7 * REF_HALF), YES, "too few edges");
    chk(32'({pins, ref_ext, is26}), 32'h0000_00FB, "out mode");
    @(posedge aclk);
    axr(ADDR_STATUS[7:0], r32, r2);
    chk(r32, 32'h0000_040F, "status out");
    // manual reset, 200 ns low, reference gone
    ref_run <= 1'b0;
    axw(8'h00, 32'h0000_0005, 1'b1, r2);
    hrst_n <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(32'({pins, vsel}), 32'h0000_010B, "held in reset");
    @(posedge aclk);
    hrst_n <= 1'b1;
    wt(dir_out, 1'b0, c);
    chk(32'(c <= DIR_MAX_CYC), YES, "dir late again");
    chk(32'(clk_oe), 32'h0000_0000, "clock pin output");
    @(posedge aclk);
    axr(8'h00, r32, r2);
    chk(r32, 32'h0000_0003, "ctrl not default");
    // each supply and enable in turn; 4 and 5 switch off the whole chip
    for (i = 0; i < 6; i++) begin
      @(posedge aclk);
      pw[i] <= 1'b0;
      repeat (6) @(negedge aclk);
      chk(32'(pins), i < 4 ? 32'h0000_0021 : YES, "off");
      @(posedge aclk);
      pw[i] <= 1'b1;
      wt(dir_out, 1'b0, c);
      chk(32'(c >= OSC_START_CYC), 32'(i >= 4), "slow clock");
    end
    tally_and_finish();
  end

  // longest path is about 28k cycles; allow well over that
  initial begin
    #(60_000 * CLK_PERIOD_NS);
    fail("watchdog expired");
    tally_and_finish();
  end
endmodule
